// ==== src/dfel_pkg.sv ====
// Package for the DMA first-error logger: register map, field layout,
// reset values and the carrier structs for error events.
// Assumes one core clock, with channel events synchronous to it.
`default_nettype none

package dfel_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_STEERING = 8'h7C; // Fatal error steering
  localparam logic [7:0] OFS_FERR_ERR = 8'h80; // First-error error bits
  localparam logic [7:0] OFS_FERR_STS_LO = 8'h84; // Status bits 31:0
  localparam logic [7:0] OFS_FERR_STS_HI = 8'h88; // Status bits 63:32
  localparam logic [7:0] OFS_NERR_ERR = 8'hBC; // Next-error error bits
  localparam logic [7:0] OFS_FERR_CMD = 8'hC0; // First-error command

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int ERR_W = 16; // Error register width
  localparam int ERR_UNAFFIL = 15; // Unaffiliated error, never set
  localparam int ERR_SOFT = 14; // Soft error, never set
  localparam int ERR_INT_CFG = 13; // Interrupt configuration
  localparam int ERR_COMPL_ADDR = 12; // Completion address
  localparam int ERR_DESC_LEN = 11; // Descriptor length
  localparam int ERR_DESC_CTRL = 10; // Descriptor control field
  localparam int ERR_WR_DATA = 9; // Destination write error
  localparam int ERR_RD_DATA = 8; // Source read error
  localparam int ERR_INT_PAR = 7; // Internal parity, never set
  localparam int ERR_CS_PAR = 6; // Chipset-reported parity
  localparam int ERR_CMD = 5; // Invalid command write
  localparam int ERR_CHAIN = 4; // Chain pointer address
  localparam int ERR_DESC = 3; // Other descriptor error
  localparam int ERR_NEXT = 2; // Next-descriptor address
  localparam int ERR_DST = 1; // Destination address
  localparam int ERR_SRC = 0; // Source address
  // Bits that can be logged at all
  localparam logic [15:0] ERR_LIVE_MASK = 16'h3F7F;

  localparam int CMD_W = 5; // Resume, abort, suspend, append, begin
  localparam int STS_DESC_LSB = 6; // Descriptor address field low bit
  localparam int STS_CHAN_LSB = 3; // Channel number field low bit
  localparam int ROUTE_W = 2; // Steering field width
  localparam int PHYS_ADDR_W = 40; // Widest legal address
  localparam int DESC_ALIGN = 6; // 64-byte descriptor alignment

  // Address check slots
  localparam int CHK_SRC = 0;
  localparam int CHK_DST = 1;
  localparam int CHK_NEXT = 2;
  localparam int CHK_CHAIN = 3;
  localparam int CHK_COMPL = 4;
  localparam int CHK_N = 5;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [1:0] RST_ROUTE = 2'h0;
  localparam logic [15:0] RST_ERR = 16'h0000;
  localparam logic [63:0] RST_STS = 64'h0;
  localparam logic [4:0] RST_CMD = 5'h00;

  // Steering codes
  typedef enum logic [1:0] {
    DFEL_ROUTE_PIN0 = 2'b00,
    DFEL_ROUTE_PIN1 = 2'b01,
    DFEL_ROUTE_PIN2 = 2'b10,
    DFEL_ROUTE_MCE = 2'b11
  } dfel_route_t;

  // One address presented for checking
  typedef struct packed {
    logic check; // Address is being checked this cycle
    logic dec_bad; // Address decoder flags it invalid
    logic [63:0] addr; // Address under check
  } dfel_addr_chk_t;

  // Error events reported by the channel logic, one-cycle pulses
  typedef struct packed {
    logic [1:0] chan; // Reporting channel
    dfel_addr_chk_t [CHK_N-1:0] chk; // Address checks
    logic compl_unconfig; // Completion address never written
    logic len_check; // Transfer length being checked
    logic [31:0] len; // Transfer length
    logic [31:0] max_len; // Limit from the transfer capability
    logic int_cfg_err; // Interrupt attempt with bad setup
    logic desc_ctrl_bad; // Illegal descriptor control value
    logic wr_data_err; // Destination write failure
    logic rd_data_err; // Source read failure
    logic parity_err; // Chipset parity error on transfer
    logic parity_on_dst; // Parity error hit destination side
    logic desc_exec_err; // Other descriptor execution error
    logic cmd_wr; // Command register written
    logic [7:0] cmd_wdata; // Value written to the command register
  } dfel_evt_t;

  // Channel context in force while the events are reported
  typedef struct packed {
    logic [63:0] chain_ptr; // Current descriptor chain pointer
    logic [4:0] cmd; // Command bits in force
    logic [2:0] xfer_state; // Transfer state
  } dfel_ctx_t;

endpackage : dfel_pkg

`default_nettype wire

// ==== src/dfel_addr_check.sv ====
// Address legality check for the DMA first-error logger.
// Assumes the address decoder verdict arrives with the address.
`default_nettype none

module dfel_addr_check #(
  parameter int ALIGN_BITS = 0 // Low bits that must be zero
) (
  input wire dfel_pkg::dfel_addr_chk_t chk, // Address under check
  output logic illegal // Address is illegal while checked
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ALIGN_BITS < 0 || ALIGN_BITS > 12) begin : g_bad_align
    $error("dfel_addr_check: ALIGN_BITS out of range");
  end

  logic too_wide; // Bits above the physical width set
  logic misaligned; // Required low bits not zero

  // ************************************************************
  // Check
  // ************************************************************
  // Decoder invalid, too wide or misaligned all count as illegal
  always_comb begin
    too_wide = |chk.addr[63:dfel_pkg::PHYS_ADDR_W];
    misaligned = 1'b0;
    if (ALIGN_BITS > 0) begin
      misaligned = |(chk.addr[11:0] & ((12'h001 << ALIGN_BITS) - 12'h001));
    end
    illegal = chk.check & (chk.dec_bad | too_wide | misaligned);
  end

endmodule // dfel_addr_check

`default_nettype wire

// ==== src/dfel_cmd_check.sv ====
// Command write check for the DMA first-error logger.
// Assumes the written value is presented with its write strobe.
`default_nettype none

module dfel_cmd_check (
  input wire logic [7:0] wdata, // Value written to the command reg
  output logic invalid // More than one command bit set
);

  logic [2:0] ones; // Count of command bits set

  // ************************************************************
  // Count the command bits
  // ************************************************************
  always_comb begin
    ones = 3'h0;
    for (int i = 0; i < dfel_pkg::CMD_W; i++) begin
      ones = ones + {2'h0, wdata[i]};
    end
    invalid = (ones > 3'h1);
  end

endmodule // dfel_cmd_check

`default_nettype wire

// ==== src/dfel_logger.sv ====
// DMA first-error logger: sticky first-error and next-error capture,
// command snapshot, failing channel and descriptor, fatal steering.
// Assumes channel events are one-cycle pulses in the pclk domain and
// that sticky_rstn is only asserted at power-up, not at warm reset.
//
// The APB slave port was chosen for this implementation.
`default_nettype none

module dfel_logger #(
  parameter int ADDR_W = 8 // APB address width
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Warm reset, active low
  input wire logic sticky_rstn, // Power-up reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error for unmapped address
  input wire dfel_pkg::dfel_evt_t evt, // Channel error events
  input wire dfel_pkg::dfel_ctx_t ctx, // Channel context
  output logic [2:0] err_pin, // Platform error pins
  output logic machine_check_error_out // Machine-check error output
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (ADDR_W < 8) begin : g_bad_addr
    $error("dfel_logger: ADDR_W must be at least 8");
  end

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [dfel_pkg::CHK_N-1:0] addr_bad; // Per-slot address verdict
  logic cmd_bad; // Command write is invalid
  logic [15:0] raw_err; // Error bits raised this cycle
  logic any_err; // Any error raised this cycle
  logic capture; // Take a new first error
  logic [15:0] wclr; // Write-one-clear mask from APB
  logic wr_go; // APB write takes effect
  logic [7:0] addr_lo; // Low address byte
  logic addr_hit; // Address is mapped
  logic [31:0] rd_word; // Read mux result

  // Sticky state
  dfel_pkg::dfel_route_t route_sel; // Fatal error steering
  logic [15:0] ferr_err; // First-error error bits
  logic [63:0] ferr_sts; // First-error status
  logic [4:0] ferr_cmd; // First-error command snapshot
  logic [15:0] nerr_err; // Next-error error bits
  dfel_pkg::dfel_route_t next_route_sel;
  logic [15:0] next_ferr_err;
  logic [63:0] next_ferr_sts;
  logic [4:0] next_ferr_cmd;
  logic [15:0] next_nerr_err;

  // Bus and pin state
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [2:0] next_err_pin;
  logic next_machine_check_error_out;

  // ************************************************************
  // Checkers
  // ************************************************************
  // One address checker per slot; descriptor addresses need 64 bytes
  for (genvar i = 0; i < dfel_pkg::CHK_N; i++) begin : g_chk
    localparam int ALIGN = (i == dfel_pkg::CHK_NEXT ||
                            i == dfel_pkg::CHK_CHAIN) ?
                           dfel_pkg::DESC_ALIGN : 0;
    dfel_addr_check #(
      .ALIGN_BITS(ALIGN)
    ) u_addr_check (
      .chk(evt.chk[i]),
      .illegal(addr_bad[i])
    );
  end

  // Command write checker
  dfel_cmd_check u_cmd_check (
    .wdata(evt.cmd_wdata),
    .invalid(cmd_bad)
  );

  // ************************************************************
  // Error classification
  // ************************************************************
  // Build the error word raised this cycle
  always_comb begin
    raw_err = 16'h0000;
    raw_err[dfel_pkg::ERR_INT_CFG] = evt.int_cfg_err;
    raw_err[dfel_pkg::ERR_COMPL_ADDR] =
      addr_bad[dfel_pkg::CHK_COMPL] |
      (evt.chk[dfel_pkg::CHK_COMPL].check & evt.compl_unconfig);
    raw_err[dfel_pkg::ERR_DESC_LEN] = evt.len_check &
      ((evt.len == 32'h0) | (evt.len > evt.max_len));
    raw_err[dfel_pkg::ERR_DESC_CTRL] = evt.desc_ctrl_bad;
    raw_err[dfel_pkg::ERR_WR_DATA] = evt.wr_data_err |
      (evt.parity_err & evt.parity_on_dst);
    raw_err[dfel_pkg::ERR_RD_DATA] = evt.rd_data_err |
      (evt.parity_err & ~evt.parity_on_dst);
    raw_err[dfel_pkg::ERR_CS_PAR] = evt.parity_err;
    raw_err[dfel_pkg::ERR_CMD] = evt.cmd_wr & cmd_bad;
    raw_err[dfel_pkg::ERR_CHAIN] = addr_bad[dfel_pkg::CHK_CHAIN];
    raw_err[dfel_pkg::ERR_DESC] = evt.desc_exec_err;
    raw_err[dfel_pkg::ERR_NEXT] = addr_bad[dfel_pkg::CHK_NEXT];
    raw_err[dfel_pkg::ERR_DST] = addr_bad[dfel_pkg::CHK_DST];
    raw_err[dfel_pkg::ERR_SRC] = addr_bad[dfel_pkg::CHK_SRC];
    // Unaffiliated, soft and internal parity are never detected
    raw_err = raw_err & dfel_pkg::ERR_LIVE_MASK;
    any_err = |raw_err;
    // Only an empty first-error log takes a new capture
    capture = any_err & (ferr_err == 16'h0000);
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  // Address decode, write strobe and read mux
  always_comb begin
    addr_lo = paddr[7:0];
    // Bits above the low byte must be zero; no zero-width replication
    addr_hit = ((paddr >> 8) == '0) &&
               (addr_lo == dfel_pkg::OFS_STEERING ||
                addr_lo == dfel_pkg::OFS_FERR_ERR ||
                addr_lo == dfel_pkg::OFS_FERR_STS_LO ||
                addr_lo == dfel_pkg::OFS_FERR_STS_HI ||
                addr_lo == dfel_pkg::OFS_NERR_ERR ||
                addr_lo == dfel_pkg::OFS_FERR_CMD);
    wr_go = psel & penable & pready & pwrite & addr_hit;
    wclr = 16'h0000;
    rd_word = 32'h0000_0000;
    unique case (addr_lo)
      dfel_pkg::OFS_STEERING: begin
        rd_word = {30'h0, route_sel};
      end
      dfel_pkg::OFS_FERR_ERR: begin
        rd_word = {16'h0000, ferr_err};
      end
      dfel_pkg::OFS_FERR_STS_LO: begin
        rd_word = ferr_sts[31:0];
      end
      dfel_pkg::OFS_FERR_STS_HI: begin
        rd_word = ferr_sts[63:32];
      end
      dfel_pkg::OFS_NERR_ERR: begin
        rd_word = {16'h0000, nerr_err};
      end
      dfel_pkg::OFS_FERR_CMD: begin
        rd_word = {27'h0, ferr_cmd};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
    if (wr_go) begin
      wclr = pwdata[15:0];
    end
  end

  // ************************************************************
  // Sticky log registers
  // ************************************************************
  // Next values: a capture or set in the same cycle beats a clear
  always_comb begin
    next_route_sel = route_sel;
    next_ferr_err = ferr_err;
    next_ferr_sts = ferr_sts;
    next_ferr_cmd = ferr_cmd;
    next_nerr_err = nerr_err;
    // Steering field is plain read/write
    if (wr_go && addr_lo == dfel_pkg::OFS_STEERING) begin
      next_route_sel = dfel_pkg::dfel_route_t'(pwdata[1:0]);
    end
    // Software writes ones to clear logged bits
    if (wr_go && addr_lo == dfel_pkg::OFS_FERR_ERR) begin
      next_ferr_err = ferr_err & ~wclr;
    end
    if (wr_go && addr_lo == dfel_pkg::OFS_FERR_STS_LO) begin
      next_ferr_sts[31:0] = ferr_sts[31:0] & ~pwdata;
    end
    if (wr_go && addr_lo == dfel_pkg::OFS_FERR_STS_HI) begin
      next_ferr_sts[63:32] = ferr_sts[63:32] & ~pwdata;
    end
    if (wr_go && addr_lo == dfel_pkg::OFS_FERR_CMD) begin
      next_ferr_cmd = ferr_cmd & ~pwdata[4:0];
    end
    if (wr_go && addr_lo == dfel_pkg::OFS_NERR_ERR) begin
      next_nerr_err = nerr_err & ~wclr;
    end
    // First error: record bits, channel, descriptor and command
    if (capture) begin
      next_ferr_err = raw_err;
      next_ferr_sts = {ctx.chain_ptr[63:dfel_pkg::STS_DESC_LSB],
                       1'b0, evt.chan,
                       ctx.xfer_state};
      // An invalid command write records the offending value
      if (raw_err[dfel_pkg::ERR_CMD]) begin
        next_ferr_cmd = evt.cmd_wdata[4:0];
      end else begin
        next_ferr_cmd = ctx.cmd;
      end
    end else if (any_err) begin
      // Log is full: note only error types not already first
      next_nerr_err = next_nerr_err | (raw_err & ~ferr_err);
    end
  end

  // Sticky registers survive warm reset
  always_ff @(posedge pclk or negedge sticky_rstn) begin
    if (!sticky_rstn) begin
      route_sel <= dfel_pkg::dfel_route_t'(dfel_pkg::RST_ROUTE);
      ferr_err <= dfel_pkg::RST_ERR;
      ferr_sts <= dfel_pkg::RST_STS;
      ferr_cmd <= dfel_pkg::RST_CMD;
      nerr_err <= dfel_pkg::RST_ERR;
    end else begin
      route_sel <= next_route_sel;
      ferr_err <= next_ferr_err;
      ferr_sts <= next_ferr_sts;
      ferr_cmd <= next_ferr_cmd;
      nerr_err <= next_nerr_err;
    end
  end

  // ************************************************************
  // APB answer
  // ************************************************************
  // Read data and error latched in setup, ready for the access cycle
  always_comb begin
    next_pready = psel & ~penable;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_prdata = pwrite ? 32'h0000_0000 : rd_word;
      next_pslverr = ~addr_hit;
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ************************************************************
  // Fatal error steering
  // ************************************************************
  // Pulse the steered output for one cycle per first-error capture
  always_comb begin
    next_err_pin = 3'h0;
    next_machine_check_error_out = 1'b0;
    if (capture) begin
      unique case (route_sel)
        dfel_pkg::DFEL_ROUTE_PIN0: next_err_pin = 3'h1;
        dfel_pkg::DFEL_ROUTE_PIN1: next_err_pin = 3'h2;
        dfel_pkg::DFEL_ROUTE_PIN2: next_err_pin = 3'h4;
        dfel_pkg::DFEL_ROUTE_MCE: begin
          next_machine_check_error_out = 1'b1;
        end
      endcase
    end
  end

  // Platform error outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_pin <= 3'h0;
      machine_check_error_out <= 1'b0;
    end else begin
      err_pin <= next_err_pin;
      machine_check_error_out <= next_machine_check_error_out;
    end
  end

endmodule // dfel_logger

`default_nettype wire

// ==== dv/dfel_logger_checker.sv ====
// Checker for the DMA first-error logger, bound to its top module.
// Assumes the APB master and the channel model keep the contract.
`default_nettype none

module dfel_logger_checker #(
  parameter int ADDR_W = 8 // APB address width
) (
  input wire logic pclk, // Core clock
  input wire logic presetn, // Warm reset, active low
  input wire logic sticky_rstn, // Power-up reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire dfel_pkg::dfel_evt_t evt, // Channel events
  input wire dfel_pkg::dfel_ctx_t ctx, // Channel context
  input wire logic [2:0] err_pin, // Error pins
  input wire logic machine_check_error_out // Machine-check output
);
  // ************************************************************
  // Steering shadow
  // ************************************************************
  logic [1:0] route; // Steering field seen on the bus
  logic [1:0] next_route; // Next steering value
  logic acc; // Completed access this cycle

  assign acc = psel && penable && pready;

  // Follow steering writes
  always_comb begin
    next_route = route;
    if (acc && pwrite && paddr == ADDR_W'(dfel_pkg::OFS_STEERING)) begin
      next_route = pwdata[1:0];
    end
  end

  // Steering shadow is sticky like the real field
  always_ff @(posedge pclk or negedge sticky_rstn) begin
    if (!sticky_rstn) begin
      route <= 2'h0;
    end else begin
      route <= next_route;
    end
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !sticky_rstn);

  property p_route;
    (|err_pin || machine_check_error_out) |->
      {machine_check_error_out, err_pin} == (4'h1 << route);
  endproperty
  a_route: assert property (p_route) else $error("wrong pin");
  property p_steer_rd;
    acc && !pwrite && paddr == ADDR_W'(dfel_pkg::OFS_STEERING) |->
      prdata == {30'h0, route};
  endproperty
  a_steer_rd: assert property (p_steer_rd) else $error("steer rd");
  property p_onehot;
    $onehot0({machine_check_error_out, err_pin});
  endproperty
  a_onehot: assert property (p_onehot) else $error("two pins");
  property p_pin_pulse;
    (|err_pin || machine_check_error_out) |=>
      !(|err_pin || machine_check_error_out);
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("long");
  property p_pin_cause;
    (|err_pin || machine_check_error_out) |-> $past(evt) != '0;
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("cause");
  property p_hw_zero;
    acc && !pwrite && paddr == ADDR_W'(dfel_pkg::OFS_FERR_ERR) |->
      prdata[15:14] == 2'h0;
  endproperty
  a_hw_zero: assert property (p_hw_zero) else $error("bit15/14");
  property p_par_zero;
    acc && !pwrite && paddr == ADDR_W'(dfel_pkg::OFS_FERR_ERR) |->
      !prdata[7];
  endproperty
  a_par_zero: assert property (p_par_zero) else $error("bit7");
  property p_setup_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_setup_rdy: assert property (p_setup_rdy) else $error("rdy");

  c_mce: cover property (machine_check_error_out);
  c_pin2: cover property (err_pin[2]);
  c_slverr: cover property (pslverr);
endmodule : dfel_logger_checker

bind dfel_logger dfel_logger_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .sticky_rstn(sticky_rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .evt(evt), .ctx(ctx), .err_pin(err_pin),
  .machine_check_error_out(machine_check_error_out));

`default_nettype wire

// ==== dv/dfel_chan_model.sv ====
// Channel-side model: turns a kind code into one-cycle error events.
// Assumes go is held for one clock per event by the bench.
`default_nettype none

module dfel_chan_model (
  input wire logic pclk, // Core clock
  input wire logic go, // Raise one event next cycle
  input wire logic [3:0] kind, // Event kind
  output dfel_pkg::dfel_evt_t evt, // Event pulses
  output dfel_pkg::dfel_ctx_t ctx // Context in force
);
  // Fixed context: invalid command mix, halted transfer
  assign ctx = {64'h0000_00AB_CDEF_0040, 5'h11, 3'h3};

  // One event per go, idle otherwise
  always @(posedge pclk) begin : gen
    dfel_pkg::dfel_evt_t e;
    e = '0;
    if (go) begin
      e.chan = kind[1:0];
      case (kind)
        4'd0: e.int_cfg_err = 1'b1;
        4'd1: begin
          e.chk[4].check = 1'b1;
          e.compl_unconfig = 1'b1;
        end
        4'd2: begin
          e.len_check = 1'b1;
          e.max_len = 32'h0000_0100;
        end
        4'd3: e.desc_ctrl_bad = 1'b1;
        4'd4: e.wr_data_err = 1'b1;
        4'd5: e.rd_data_err = 1'b1;
        4'd6: e.parity_err = 1'b1;
        4'd7: begin
          e.cmd_wr = 1'b1;
          e.cmd_wdata = 8'h06;
        end
        4'd8: begin
          e.chk[3].check = 1'b1;
          e.chk[3].addr = 64'h1020;
        end
        4'd9: e.desc_exec_err = 1'b1;
        4'd10: begin
          e.chk[2].check = 1'b1;
          e.chk[2].addr = 64'h100_0000_0000;
        end
        4'd11: begin
          e.chk[1].check = 1'b1;
          e.chk[1].dec_bad = 1'b1;
        end
        default: begin
          e.chk[0].check = 1'b1;
          e.chk[0].dec_bad = 1'b1;
        end
      endcase
    end
    evt <= e;
  end
endmodule : dfel_chan_model

`default_nettype wire

// ==== dv/tb.sv ====
// Testbench for the DMA first-error logger: APB tasks and scenarios.
// Assumes the channel model drives events and the checker is bound.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, sticky_rstn, psel, penable, pwrite; // Bus side
  logic [7:0] paddr; // Byte address
  logic [31:0] pwdata, prdata, r; // Data words
  logic pready, pslverr, mce, go, e; // Status and event strobe
  logic [2:0] err_pin; // Error pins
  logic [3:0] kind; // Event kind
  dfel_pkg::dfel_evt_t evt; // Events
  dfel_pkg::dfel_ctx_t ctx; // Context
  int n_fail = 0, n_tests = 0, cyc = 0; // Counters
  // Expected first-error bits per event kind
  logic [15:0] mask [13] = '{16'h2000, 16'h1000, 16'h0800, 16'h0400,
    16'h0200, 16'h0100, 16'h0140, 16'h0020, 16'h0010, 16'h0008,
    16'h0004, 16'h0002, 16'h0001};
  logic [7:0] ofs [6] = '{8'h7C, 8'h80, 8'h84, 8'h88, 8'hBC, 8'hC0};

  dfel_logger #(.ADDR_W(8)) DUT (.pclk(pclk), .presetn(presetn),
    .sticky_rstn(sticky_rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .evt(evt), .ctx(ctx),
    .err_pin(err_pin), .machine_check_error_out(mce));
  dfel_chan_model u_model (.pclk(pclk), .go(go), .kind(kind),
    .evt(evt), .ctx(ctx));

  // Clock at 125 MHz
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, r, x);
  endtask

  // Raise one event and look at the pins the cycle they pulse
  task automatic fire(input int k, input logic [3:0] pins);
    @(posedge pclk);
    go <= 1'b1;
    kind <= k[3:0];
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
    #1;
    chk("pins", {28'h0, mce, err_pin}, {28'h0, pins});
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {presetn, sticky_rstn, psel, penable, pwrite, go} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    kind = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sticky_rstn <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0, "reset");
    $display("test reset done");
    // Every error kind, steering code cycling k mod 4 through all four
    for (int k = 0; k < 13; k++) begin
      wr(8'h7C, 32'hFFFF_FFFC | (k % 4));
      rd(8'h7C, k % 4, "steer");
      fire(k, 4'h1 << (k % 4));
      rd(8'h80, {16'h0, mask[k]}, "ferr");
      rd(8'h84, 32'hCDEF_0043 | ((k % 4) << 3), "sts lo");
      rd(8'h88, 32'h0000_00AB, "sts hi");
      rd(8'hC0, (k == 7) ? 32'h6 : 32'h11, "cmd");
      wr(8'h80, {16'h0, mask[k]});
      wr(8'h84, 32'hFFFF_FFFF);
      wr(8'h88, 32'hFFFF_FFFF);
      wr(8'hC0, 32'h1F);
      rd(8'h80, 32'h0, "clear");
    end
    $display("test capture done");
    // Later errors are blocked; only new error types go to next-error bits
    fire(0, 4'h1);
    fire(4, 4'h0);
    fire(0, 4'h0);
    rd(8'h80, 32'h2000, "first kept");
    rd(8'hBC, 32'h0200, "next");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h80, 32'h2000, "sticky");
    wr(8'h80, 32'h2000);
    wr(8'hBC, 32'hFFFF);
    rd(8'hBC, 32'h0, "next clear");
    $display("test next done");
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk("slverr", {31'h0, e}, 32'h1);
    chk("unmapped", r, 32'h0);
    $display("test unmapped done");
    conclude();
  end
endmodule : tb

`default_nettype wire
